// >>> rtl/tcppc_pkg.sv
// Purpose: Shared constants of the cascade, PWM and phase counting timer
// Assumes: Two 16-bit channels, index 0 is channel 1, index 1 is channel 2
// Notes: Encodings below are used by the top and by the phase decoder
package tcppc_pkg;
    localparam int CNT_W = 16;
    localparam int CH_N = 2;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] GR_RST = 16'hFFFF;
    // Output control field
    localparam logic [1:0] OUT_HOLD = 2'h0;
    localparam logic [1:0] OUT_LOW = 2'h1;
    localparam logic [1:0] OUT_HIGH = 2'h2;
    localparam logic [1:0] OUT_TOG = 2'h3;
    // Counter clear select
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A = 2'h1;
    localparam logic [1:0] CLR_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    // Waveform mode
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PWM1 = 2'h1;
    localparam logic [1:0] MODE_PWM2 = 2'h2;
    // Channel 1 count source
    localparam logic SRC_INTERNAL = 1'b0;
    localparam logic SRC_CASCADE = 1'b1;
    // Capture edge select
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Phase counting sub-modes
    localparam logic [1:0] PHASE_M1 = 2'h0;
    localparam logic [1:0] PHASE_M2 = 2'h1;
    localparam logic [1:0] PHASE_M3 = 2'h2;
    localparam logic [1:0] PHASE_M4 = 2'h3;
    // Reset values of the direction flag and the pin levels
    localparam logic DIR_RST = 1'b1;
    localparam logic LEVEL_RST = 1'b0;
endpackage : tcppc_pkg

// >>> rtl/tcppc_qdec_if.sv
// Purpose: Carries count pulses from the phase decoder to the core
// Assumes: Both pulses are one clock long and never high together
// Notes: dec drives, core listens
interface tcppc_qdec_if;
    logic up;
    logic down;
    modport dec (output up, output down);
    modport core (input up, input down);
endinterface : tcppc_qdec_if

// >>> rtl/tcppc_qdec.sv
// Purpose: Two-phase external clock decoder for phase counting
// Assumes: Phase pins are asynchronous to clk_in
// Notes: Pulses lag the pins by three clocks
module tcppc_qdec (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic phase_a_in, // Phase A pin
    input wire logic phase_b_in, // Phase B pin
    input wire logic [1:0] mode_in, // Sub-mode select
    tcppc_qdec_if.dec pulse // Up and down pulses
);
    typedef struct packed {
        logic a_s1;
        logic a_s2;
        logic a_s3;
        logic b_s1;
        logic b_s2;
        logic b_s3;
        logic up;
        logic down;
    } tcppc_qdec_s;

    tcppc_qdec_s r;
    tcppc_qdec_s n;

    always_comb begin
        logic ar, af, br, bf, ah, bh;
        ar = 1'b0;
        af = 1'b0;
        br = 1'b0;
        bf = 1'b0;
        ah = 1'b0;
        bh = 1'b0;
        n = r;
        n.a_s1 = phase_a_in;
        n.a_s2 = r.a_s1;
        n.a_s3 = r.a_s2;
        n.b_s1 = phase_b_in;
        n.b_s2 = r.b_s1;
        n.b_s3 = r.b_s2;
        // Edges come from successive synchronised samples only
        ar = r.a_s2 & ~r.a_s3;
        af = ~r.a_s2 & r.a_s3;
        br = r.b_s2 & ~r.b_s3;
        bf = ~r.b_s2 & r.b_s3;
        ah = r.a_s2;
        bh = r.b_s2;
        case (mode_in)
            tcppc_pkg::PHASE_M1: begin
                n.up = (ah & br) | (~ah & bf) | (ar & ~bh) | (af & bh);
                n.down = (ah & bf) | (~ah & br) | (ar & bh) | (af & ~bh);
            end
            tcppc_pkg::PHASE_M2: begin
                n.up = af & bh;
                n.down = af & ~bh;
            end
            tcppc_pkg::PHASE_M3: begin
                n.up = af & bh;
                n.down = ah & bf;
            end
            default: begin
                n.up = (ah & br) | (~ah & bf);
                n.down = (ah & bf) | (~ah & br);
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pulse.up = r.up;
    assign pulse.down = r.down;
endmodule : tcppc_qdec

// >>> rtl/tcppc_top.sv
// Purpose: Two-channel 16-bit timer with cascade, PWM and phase counting
// Assumes: Index 0 is channel 1, index 1 is channel 2
// Notes: Control bits are plain ports; no register bus
module tcppc_top (
    input wire logic clk_in, // Clock, 250 MHz
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic [1:0] run_in, // Counter start per channel
    input wire logic clock_select_field_in, // Ch1 source: ch2 overflow
    input wire logic [1:0][1:0] pwm_mode_in, // Waveform mode per channel
    input wire logic [1:0] phase_en_in, // Phase counting enable
    input wire logic [1:0][1:0] phase_mode_in, // Phase sub-mode
    input wire logic [1:0][1:0] counter_clear_select_in, // Clear source
    input wire logic [1:0][1:0] pin_a_output_setting_in, // Match A action
    input wire logic [1:0][1:0] pin_b_output_setting_in, // Match B action
    input wire logic [1:0] init_level_a_in, // Pin A initial level
    input wire logic [1:0] init_level_b_in, // Pin B initial level
    input wire logic [1:0] capture_a_en_in, // Register A captures
    input wire logic [1:0][1:0] capture_edge_in, // Capture edge select
    input wire logic [1:0] reg_wr_in, // Write strobe per channel
    input wire logic [1:0] reg_sel_in, // 0 counter, 1 reg A, 2 reg B
    input wire logic [15:0] wr_data_in, // Write data
    input wire logic [1:0] ovf_clr_in, // Clear overflow flag
    input wire logic [1:0] unf_clr_in, // Clear underflow flag
    input wire logic [1:0] underflow_int_enable_in, // Underflow req enable
    input wire logic ext_clock_in_a, // Ch1 phase A pin
    input wire logic ext_clock_in_b, // Ch1 phase B pin
    input wire logic ext_clock_in_c, // Ch2 phase A pin
    input wire logic ext_clock_in_d, // Ch2 phase B pin
    input wire logic [1:0] capture_compare_pin_a_in, // Capture pin level
    output logic [1:0][15:0] timer_counter_value_out, // Counters
    output logic [1:0][15:0] general_reg_a_out, // Register A
    output logic [1:0][15:0] general_reg_b_out, // Register B
    output logic [1:0] pin_a_out, // Pin A level
    output logic [1:0] pin_a_oe_out, // Pin A drive enable
    output logic [1:0] pin_b_out, // Pin B level
    output logic [1:0] pin_b_oe_out, // Pin B drive enable
    output logic [1:0] overflow_flag_out, // Overflow flags
    output logic [1:0] underflow_flag_out, // Underflow flags
    output logic [1:0] count_direction_flag_out, // 1 up, 0 down
    output logic [1:0] underflow_irq_out // Underflow request
);
    localparam logic [1:0] SEL_CNT = 2'h0;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;

    typedef struct packed {
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] gra;
        logic [1:0][15:0] grb;
        logic [1:0] pa;
        logic [1:0] pa_oe;
        logic [1:0] pb;
        logic [1:0] pb_oe;
        logic [1:0] ovf;
        logic [1:0] unf;
        logic [1:0] dir;
        logic [1:0] irq;
        logic [1:0] cap_s1;
        logic [1:0] cap_s2;
        logic [1:0] cap_s3;
    } tcppc_state_s;

    tcppc_state_s r;
    tcppc_state_s n;
    logic [1:0] qd_up;
    logic [1:0] qd_dn;
    logic [1:0] ph_a;
    logic [1:0] ph_b;

    function automatic logic out_level(input logic [1:0] setting,
                                       input logic cur);
        logic v;
        v = cur;
        case (setting)
            tcppc_pkg::OUT_LOW: v = 1'b0;
            tcppc_pkg::OUT_HIGH: v = 1'b1;
            tcppc_pkg::OUT_TOG: v = ~cur;
            default: v = cur;
        endcase
        return v;
    endfunction : out_level

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic now,
                                      input logic prev);
        return (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
    endfunction : edge_hit

    // Channel 1 reads pins A/B, channel 2 reads pins C/D
    assign ph_a = {ext_clock_in_c, ext_clock_in_a};
    assign ph_b = {ext_clock_in_d, ext_clock_in_b};

    genvar g;
    generate
        for (g = 0; g < tcppc_pkg::CH_N; g++) begin : g_dec
            tcppc_qdec_if qd ();
            tcppc_qdec u_dec (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .phase_a_in(ph_a[g]),
                .phase_b_in(ph_b[g]),
                .mode_in(phase_mode_in[g]),
                .pulse(qd.dec)
            );
            assign qd_up[g] = qd.up;
            assign qd_dn[g] = qd.down;
        end
    endgenerate

    always_comb begin
        logic [1:0] ma, mb, cap, own_clr, clr, up, dn, wrap_up, wrap_dn;
        logic [1:0][15:0] pval;
        logic [1:0][1:0] sel;
        int c;
        ma = '0;
        mb = '0;
        cap = '0;
        own_clr = '0;
        clr = '0;
        up = '0;
        dn = '0;
        wrap_up = '0;
        wrap_dn = '0;
        pval = '0;
        sel = counter_clear_select_in;
        c = 0;
        n = r;
        n.cap_s1 = capture_compare_pin_a_in;
        n.cap_s2 = r.cap_s1;
        n.cap_s3 = r.cap_s2;

        // Matches, captures and own clear sources
        for (int i = 0; i < tcppc_pkg::CH_N; i++) begin
            cap[i] = capture_a_en_in[i]
                     & edge_hit(capture_edge_in[i], r.cap_s2[i],
                                r.cap_s3[i]);
            ma[i] = run_in[i] & ~capture_a_en_in[i]
                    & (r.cnt[i] == r.gra[i]);
            mb[i] = run_in[i] & (r.cnt[i] == r.grb[i]);
            // Clear by compare stays valid in phase counting
            own_clr[i] = ((sel[i] == tcppc_pkg::CLR_A) & (ma[i] | cap[i]))
                         | ((sel[i] == tcppc_pkg::CLR_B) & mb[i]);
            pval[i] = (sel[i] == tcppc_pkg::CLR_A) ? r.gra[i] : r.grb[i];
        end

        // Synchronous clear follows the other channel's own clear
        for (int i = 0; i < tcppc_pkg::CH_N; i++) begin
            clr[i] = own_clr[i] | ((sel[i] == tcppc_pkg::CLR_SYNC)
                                   & own_clr[1 - i]);
            if (sel[i] == tcppc_pkg::CLR_SYNC) begin
                pval[i] = pval[1 - i];
            end
        end

        // Channel 2 first so channel 1 can see its wrap
        for (int i = 0; i < tcppc_pkg::CH_N; i++) begin
            c = tcppc_pkg::CH_N - 1 - i;
            if (!run_in[c]) begin
                up[c] = 1'b0;
                dn[c] = 1'b0;
            end else if (phase_en_in[c]) begin
                // Clock select ignored while phase counting
                up[c] = qd_up[c];
                dn[c] = qd_dn[c];
            end else if (c == 0
                         && clock_select_field_in
                            == tcppc_pkg::SRC_CASCADE) begin
                up[c] = wrap_up[1];
                dn[c] = 1'b0;
            end else begin
                up[c] = 1'b1;
                dn[c] = 1'b0;
            end
            wrap_up[c] = up[c] & ~clr[c] & (r.cnt[c] == tcppc_pkg::CNT_MAX);
            wrap_dn[c] = dn[c] & ~clr[c] & (r.cnt[c] == tcppc_pkg::CNT_RST);
        end

        for (int i = 0; i < tcppc_pkg::CH_N; i++) begin
            // Counter update
            if (clr[i]) begin
                n.cnt[i] = tcppc_pkg::CNT_RST;
            end else if (up[i]) begin
                n.cnt[i] = r.cnt[i] + tcppc_pkg::CNT_ONE;
            end else if (dn[i]) begin
                n.cnt[i] = r.cnt[i] - tcppc_pkg::CNT_ONE;
            end
            if (up[i]) begin
                n.dir[i] = 1'b1;
            end else if (dn[i]) begin
                n.dir[i] = 1'b0;
            end

            // Each half captures its own counter
            if (cap[i]) begin
                n.gra[i] = r.cnt[i];
            end

            // Software writes; a write to the counter beats the count
            if (reg_wr_in[i]) begin
                if (reg_sel_in == SEL_CNT) begin
                    n.cnt[i] = wr_data_in;
                end else if (reg_sel_in == SEL_A) begin
                    n.gra[i] = wr_data_in;
                end else if (reg_sel_in == SEL_B) begin
                    n.grb[i] = wr_data_in;
                end
            end

            // Set wins over a clear in the same cycle
            n.ovf[i] = (r.ovf[i] & ~ovf_clr_in[i]) | wrap_up[i];
            n.unf[i] = (r.unf[i] & ~unf_clr_in[i]) | wrap_dn[i];
            n.irq[i] = n.unf[i] & underflow_int_enable_in[i];

            // Pin waveforms
            if (!run_in[i]) begin
                // Idle pins sit at their initial levels
                n.pa[i] = init_level_a_in[i];
                n.pb[i] = init_level_b_in[i];
                n.pa_oe[i] = ~capture_a_en_in[i];
                n.pb_oe[i] = pwm_mode_in[i] != tcppc_pkg::MODE_PWM1;
            end else begin
                case (pwm_mode_in[i])
                    tcppc_pkg::MODE_PWM1: begin
                        // Pin B is not a PWM mode 1 output
                        n.pa_oe[i] = 1'b1;
                        n.pb_oe[i] = 1'b0;
                        if (r.gra[i] == r.grb[i]) begin
                            n.pa[i] = r.pa[i];
                        end else if (ma[i]) begin
                            n.pa[i] = out_level(pin_a_output_setting_in[i],
                                                r.pa[i]);
                        end else if (mb[i]) begin
                            n.pa[i] = out_level(pin_b_output_setting_in[i],
                                                r.pa[i]);
                        end
                    end
                    tcppc_pkg::MODE_PWM2: begin
                        // Period register pin is left undriven
                        n.pa_oe[i] = sel[i] != tcppc_pkg::CLR_A;
                        n.pb_oe[i] = sel[i] != tcppc_pkg::CLR_B;
                        if (clr[i]) begin
                            n.pa[i] = init_level_a_in[i];
                            n.pb[i] = init_level_b_in[i];
                        end else begin
                            if (ma[i] && r.gra[i] != pval[i]) begin
                                n.pa[i] = out_level(
                                    pin_a_output_setting_in[i],
                                    r.pa[i]);
                            end
                            if (mb[i] && r.grb[i] != pval[i]) begin
                                n.pb[i] = out_level(
                                    pin_b_output_setting_in[i],
                                    r.pb[i]);
                            end
                        end
                    end
                    default: begin
                        n.pa_oe[i] = ~capture_a_en_in[i];
                        n.pb_oe[i] = 1'b1;
                        if (ma[i]) begin
                            n.pa[i] = out_level(pin_a_output_setting_in[i],
                                                r.pa[i]);
                        end
                        if (mb[i]) begin
                            n.pb[i] = out_level(pin_b_output_setting_in[i],
                                                r.pb[i]);
                        end
                    end
                endcase
            end
        end
        // Modes are per channel with no cross lock
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r <= '0;
            r.gra <= {tcppc_pkg::GR_RST, tcppc_pkg::GR_RST};
            r.grb <= {tcppc_pkg::GR_RST, tcppc_pkg::GR_RST};
            r.dir <= {tcppc_pkg::DIR_RST, tcppc_pkg::DIR_RST};
            r.pa <= {tcppc_pkg::LEVEL_RST, tcppc_pkg::LEVEL_RST};
            r.pb <= {tcppc_pkg::LEVEL_RST, tcppc_pkg::LEVEL_RST};
        end else begin
            r <= n;
        end
    end

    assign timer_counter_value_out = r.cnt;
    assign general_reg_a_out = r.gra;
    assign general_reg_b_out = r.grb;
    assign pin_a_out = r.pa;
    assign pin_a_oe_out = r.pa_oe;
    assign pin_b_out = r.pb;
    assign pin_b_oe_out = r.pb_oe;
    assign overflow_flag_out = r.ovf;
    assign underflow_flag_out = r.unf;
    assign count_direction_flag_out = r.dir;
    assign underflow_irq_out = r.irq;
endmodule : tcppc_top

// >>> testbench/tcppc_enc.sv
// Purpose: Quadrature encoder model feeding one pair of phase pins
// Assumes: Bench calls step from its main sequence only
// Notes: Edges sit four clocks apart, above the decoder's minimum
module tcppc_enc (
    input wire logic clk_in, // Bench clock
    output logic ph_a_out, // Phase A level
    output logic ph_b_out // Phase B level
);
    timeunit 1ns;
    timeprecision 100ps;
    int pos = 0;
    // Gray sequence keeps exactly one pin moving per edge
    assign ph_a_out = (pos == 1) || (pos == 2);
    assign ph_b_out = (pos == 2) || (pos == 3);
    task automatic step(input bit up, input int n);
        repeat (n) begin
            @(negedge clk_in);
            pos = up ? (pos + 1) % 4 : (pos + 3) % 4;
            repeat (3) @(negedge clk_in);
        end
    endtask : step
endmodule : tcppc_enc

// >>> testbench/tcppc_chk.sv
// Purpose: Concurrent checks on the timer top ports
// Assumes: One clock domain, synchronous active low reset
// Notes: Bound into every instance of the top
module tcppc_chk (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic [1:0] run_in, // Run
    input wire logic clock_select_field_in, // Cascade
    input wire logic [1:0][1:0] pwm_mode_in, // Mode
    input wire logic [1:0] phase_en_in, // Phase
    input wire logic [1:0][1:0] counter_clear_select_in, // Clear
    input wire logic [1:0] reg_wr_in, // Write
    input wire logic [1:0] underflow_int_enable_in, // Enable
    input wire logic [1:0][15:0] timer_counter_value_out, // Counters
    input wire logic [1:0] pin_b_oe_out, // Pin B oe
    input wire logic [1:0] overflow_flag_out, // Overflow
    input wire logic [1:0] underflow_flag_out, // Underflow
    input wire logic [1:0] count_direction_flag_out, // Direction
    input wire logic [1:0] underflow_irq_out // Request
);
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence low_wrap_s;
        $past(timer_counter_value_out[1]) == 16'hFFFF
            && timer_counter_value_out[1] == 16'h0000;
    endsequence
    sequence carry_ready_s;
        clock_select_field_in && run_in == 2'b11 && reg_wr_in == 2'b00
            && phase_en_in == 2'b00 && counter_clear_select_in == '0
            && timer_counter_value_out[1] == 16'hFFFF;
    endsequence
    ovf_on_wrap_a: assert property ($rose(overflow_flag_out[1]) |-> low_wrap_s)
        else $error("overflow flag rose without a wrap");
    cascade_carry_a: assert property (carry_ready_s |=> low_wrap_s ##0
        timer_counter_value_out[0] == $past(timer_counter_value_out[0]) + 16'h0001)
        else $error("upper half missed the carry");
    unf_on_wrap_a: assert property ($rose(underflow_flag_out[0]) |->
        $past(timer_counter_value_out[0]) == 16'h0000
        && timer_counter_value_out[0] == 16'hFFFF)
        else $error("underflow flag rose without a wrap");
    irq_request_a: assert property (underflow_irq_out[0] ==
        (underflow_flag_out[0] && $past(underflow_int_enable_in[0])))
        else $error("underflow request disagrees with flag");
    dir_down_a: assert property ($past(phase_en_in[0]) && !$past(reg_wr_in[0])
        && timer_counter_value_out[0] == $past(timer_counter_value_out[0]) - 16'h0001
        |-> !count_direction_flag_out[0])
        else $error("direction flag not down after a decrement");
    pwm1_b_idle_a: assert property ((pwm_mode_in[0] == tcppc_pkg::MODE_PWM1) [*2]
        |-> !pin_b_oe_out[0])
        else $error("pin b driven in pwm mode 1");
    pwm2_period_a: assert property ((run_in[1] && pwm_mode_in[1] == tcppc_pkg::MODE_PWM2
        && counter_clear_select_in[1] == tcppc_pkg::CLR_B) [*2] |-> !pin_b_oe_out[1])
        else $error("period pin driven in pwm mode 2");
    stop_freeze_a: assert property (run_in == 2'b00 && reg_wr_in == 2'b00
        |=> $stable(timer_counter_value_out))
        else $error("counter moved while stopped");
endmodule : tcppc_chk
bind tcppc_top tcppc_chk i_chk (.clk_in, .rst_n_in, .run_in, .clock_select_field_in,
    .pwm_mode_in, .phase_en_in, .counter_clear_select_in, .reg_wr_in,
    .underflow_int_enable_in, .timer_counter_value_out, .pin_b_oe_out,
    .overflow_flag_out, .underflow_flag_out, .count_direction_flag_out,
    .underflow_irq_out);

// >>> testbench/tcppc_top_tb.sv
// Purpose: Self-checking bench for the cascade, PWM and phase timer
// Assumes: Inputs move on the falling clock edge only
// Notes: Two encoder models drive the phase pins of both channels
module tcppc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [1:0] run_in = '0;
    logic clock_select_field_in = 1'b0;
    logic [1:0][1:0] pwm_mode_in = '0;
    logic [1:0] phase_en_in = '0;
    logic [1:0][1:0] phase_mode_in = '0;
    logic [1:0][1:0] counter_clear_select_in = '0;
    logic [1:0][1:0] pin_a_output_setting_in = '0;
    logic [1:0][1:0] pin_b_output_setting_in = '0;
    logic [1:0] init_level_a_in = '0;
    logic [1:0] init_level_b_in = '0;
    logic [1:0] capture_a_en_in = '0;
    logic [1:0][1:0] capture_edge_in = '0;
    logic [1:0] reg_wr_in = '0;
    logic [1:0] reg_sel_in = '0;
    logic [15:0] wr_data_in = '0;
    logic [1:0] ovf_clr_in = '0;
    logic [1:0] unf_clr_in = '0;
    logic [1:0] underflow_int_enable_in = '0;
    logic [1:0] capture_compare_pin_a_in = '0;
    logic ext_clock_in_a, ext_clock_in_b, ext_clock_in_c, ext_clock_in_d;
    logic [1:0][15:0] timer_counter_value_out, general_reg_a_out;
    logic [1:0][15:0] general_reg_b_out;
    logic [1:0] pin_a_out, pin_a_oe_out, pin_b_out, pin_b_oe_out;
    logic [1:0] overflow_flag_out, underflow_flag_out;
    logic [1:0] count_direction_flag_out, underflow_irq_out;
    int miscompares = 0;
    int n_checks = 0;
    always #2 clk_in = ~clk_in;
    tcppc_enc i_enc1 (.clk_in, .ph_a_out(ext_clock_in_a), .ph_b_out(ext_clock_in_b));
    tcppc_enc i_enc2 (.clk_in, .ph_a_out(ext_clock_in_c), .ph_b_out(ext_clock_in_d));
    tcppc_top i_dut (.clk_in, .rst_n_in, .run_in, .clock_select_field_in,
        .pwm_mode_in, .phase_en_in, .phase_mode_in, .counter_clear_select_in,
        .pin_a_output_setting_in, .pin_b_output_setting_in, .init_level_a_in,
        .init_level_b_in, .capture_a_en_in, .capture_edge_in, .reg_wr_in,
        .reg_sel_in, .wr_data_in, .ovf_clr_in, .unf_clr_in,
        .underflow_int_enable_in, .ext_clock_in_a, .ext_clock_in_b,
        .ext_clock_in_c, .ext_clock_in_d, .capture_compare_pin_a_in,
        .timer_counter_value_out, .general_reg_a_out, .general_reg_b_out,
        .pin_a_out, .pin_a_oe_out, .pin_b_out, .pin_b_oe_out,
        .overflow_flag_out, .underflow_flag_out, .count_direction_flag_out,
        .underflow_irq_out);
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input int ch, input logic [1:0] sel, input logic [15:0] d);
        @(negedge clk_in);
        reg_wr_in[ch] = 1'b1;
        reg_sel_in = sel;
        wr_data_in = d;
        @(negedge clk_in);
        reg_wr_in = '0;
    endtask : wr
    // Counts whole cycles only, so a window of full periods is exact
    task automatic pwm_run(input int ch, input int n, output logic [15:0] k);
        k = '0;
        run_in[ch] = 1'b1;
        repeat (n) begin
            @(negedge clk_in);
            k = k + 16'(pin_a_out[ch] === 1'b1);
        end
        run_in[ch] = 1'b0;
    endtask : pwm_run
    task automatic t_cascade();
        int i;
        wr(1, 2'h0, 16'hFFFD);
        wr(0, 2'h0, 16'h1233);
        clock_select_field_in = tcppc_pkg::SRC_CASCADE;
        run_in = 2'b11;
        for (i = 0; i < 10 && timer_counter_value_out[1] !== 16'h0000; i++) begin
            @(negedge clk_in);
        end
        run_in = 2'b00;
        if (i == 10) begin
            miscompares++;
            report_and_stop();
        end
        chk("upper half", timer_counter_value_out[0], 16'h1234);
        chk("low overflow", overflow_flag_out, 16'h0002);
        clock_select_field_in = tcppc_pkg::SRC_INTERNAL;
        capture_a_en_in = 2'b11;
        capture_edge_in = {2{tcppc_pkg::EDGE_RISE}};
        wr(0, 2'h0, 16'hABCD);
        wr(1, 2'h0, 16'h5678);
        capture_compare_pin_a_in = 2'b11;
        repeat (6) @(negedge clk_in);
        chk("upper capture", general_reg_a_out[0], 16'hABCD);
        chk("lower capture", general_reg_a_out[1], 16'h5678);
        capture_compare_pin_a_in = 2'b00;
        capture_a_en_in = 2'b00;
        $display("cascade test done");
    endtask : t_cascade
    task automatic t_pwm(input int ch, input logic [1:0] mode,
            input logic [1:0] per_sel, input logic [1:0] duty_sel,
            input logic [15:0] per, input logic [15:0] duty,
            input logic [15:0] exp_hi);
        logic [15:0] k;
        pwm_mode_in[ch] = mode;
        counter_clear_select_in[ch] = per_sel;
        pin_a_output_setting_in[ch] = tcppc_pkg::OUT_LOW;
        pin_b_output_setting_in[ch] = tcppc_pkg::OUT_HIGH;
        if (mode == tcppc_pkg::MODE_PWM2) begin
            pin_a_output_setting_in[ch] = tcppc_pkg::OUT_HIGH;
        end
        for (int b = 0; b < 2; b++) begin
            init_level_a_in[ch] = 1'(b);
            wr(ch, 2'h0, 16'h0000);
            wr(ch, per_sel, per);
            wr(ch, duty_sel, b ? per : duty);
            pwm_run(ch, 40, k);
            chk("pwm highs", k, b ? 16'h0028 : exp_hi);
        end
        chk("pin b oe", pin_b_oe_out[ch], 16'h0000);
        chk("reg b", general_reg_b_out[ch], per);
        chk("pin ab", {pin_a_oe_out[ch], pin_b_out[ch]}, 2'h2);
        init_level_a_in[ch] = 1'b0;
        pwm_mode_in[ch] = tcppc_pkg::MODE_NORMAL;
        counter_clear_select_in[ch] = tcppc_pkg::CLR_NONE;
        $display("pwm test done");
    endtask : t_pwm
    task automatic t_phase();
        logic [15:0] exp [4] = '{16'h0004, 16'h0001, 16'h0001, 16'h0002};
        phase_en_in = 2'b11;
        underflow_int_enable_in[0] = 1'b1;
        for (int m = 0; m < 4; m++) begin
            phase_mode_in[0] = 2'(m);
            wr(0, 2'h0, 16'h0000);
            run_in[0] = 1'b1;
            i_enc1.step(1'b1, 4);
            repeat (8) @(negedge clk_in);
            chk("phase up", timer_counter_value_out[0], exp[m]);
            run_in[0] = 1'b0;
        end
        phase_mode_in[0] = tcppc_pkg::PHASE_M1;
        wr(0, 2'h0, 16'h0002);
        wr(1, 2'h0, 16'h0000);
        run_in = 2'b11;
        i_enc1.step(1'b0, 4);
        repeat (8) @(negedge clk_in);
        chk("phase down", timer_counter_value_out[0], 16'hFFFE);
        chk("underflow", underflow_flag_out[0], 16'h0001);
        chk("direction", count_direction_flag_out[0], 16'h0000);
        chk("request", underflow_irq_out[0], 16'h0001);
        unf_clr_in[0] = 1'b1;
        @(negedge clk_in);
        unf_clr_in[0] = 1'b0;
        repeat (2) @(negedge clk_in);
        chk("request cleared", underflow_irq_out[0], 16'h0000);
        i_enc2.step(1'b1, 3);
        repeat (8) @(negedge clk_in);
        chk("second pair", timer_counter_value_out[1], 16'h0003);
        chk("first untouched", timer_counter_value_out[0], 16'hFFFE);
        run_in = 2'b00;
        $display("phase test done");
    endtask : t_phase
    initial begin
        repeat (12) @(negedge clk_in);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        chk("reset reg a", general_reg_a_out[1], tcppc_pkg::GR_RST);
        chk("reset direction", count_direction_flag_out[0], 16'h0001);
        t_cascade();
        t_pwm(0, tcppc_pkg::MODE_PWM1, 2'h1, 2'h2, 16'h0009, 16'h0004, 16'h0014);
        t_pwm(1, tcppc_pkg::MODE_PWM2, 2'h2, 2'h1, 16'h0007, 16'h0003, 16'h0014);
        t_phase();
        report_and_stop();
    end
endmodule : tcppc_top_tb
